/* hw/dsle_led_top.sv */
// Purpose: status led encoder for axis controller and mains supply module
// Assumes: apb slave, zero wait states, one 100 MHz clock
// Notes: software writes conditions; leds follow with one cycle of latency
`timescale 1ns/1ns
`default_nettype none
module dsle_led_top #(
  parameter int QUICK_HALF_CYC = dsle_pkg::QUICK_HALF_CYC_DEF
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic axis_led_green_o,
  output logic axis_led_red_o,
  output logic sup_led_green_o,
  output logic sup_led_red_o,
  output logic sup_error_o,
  output logic irq_o
);
  import dsle_pkg::*;

  typedef struct packed {
    logic [AX_W-1:0] axis_ctrl;
    logic [SP_W-1:0] sup_ctrl;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    dsle_pat_type ax_grn;
    dsle_pat_type ax_red;
    dsle_pat_type sp_grn;
    dsle_pat_type sp_red;
    logic [3:0] lvl;
    logic mod_err;
    logic hw_fault;
    logic [31:0] rdata;
  } dsle_top_type;

  dsle_top_type r;
  dsle_top_type next_r;
  logic slow;
  logic quick;
  logic setup;
  logic access;
  logic mapped;
  logic wr;
  dsle_pat_type ag;
  dsle_pat_type ar;
  dsle_pat_type sg;
  dsle_pat_type sr;
  dsle_sup_state_type sst;
  logic [IRQ_W-1:0] ev;

  dsle_flash_gen #(
    .QUICK_HALF_CYC(QUICK_HALF_CYC),
    .QUICK_PER_SLOW(QUICK_PER_SLOW)
  ) u_flash (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .slow_o(slow),
    .quick_o(quick)
  );

  function automatic logic pat_level(dsle_pat_type p, logic s, logic q);
    logic v;
    v = 1'b0;
    case (p)
      PAT_OFF: v = 1'b0;
      PAT_ON: v = 1'b1;
      PAT_SLOW: v = s;
      PAT_QUICK: v = q;
      PAT_SLOW_INV: v = ~s;
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  function automatic logic is_mapped(logic [7:0] a);
    return (a == AXIS_CTRL_OFS) || (a == SUP_CTRL_OFS) ||
           (a == LED_STAT_OFS) || (a == IRQ_STAT_OFS) ||
           (a == IRQ_CLR_OFS) || (a == IRQ_EN_OFS);
  endfunction

  // axis controller pattern, highest priority first
  always_comb begin
    ag = PAT_SLOW;
    ar = PAT_OFF;
    if (!r.axis_ctrl[AX_SUPPLY_OK]) begin
      ag = PAT_OFF;
      ar = PAT_OFF;
    end else if (r.axis_ctrl[AX_HW_FAULT]) begin
      ag = PAT_ON;
      ar = PAT_ON;
    end else if (r.axis_ctrl[AX_ERR2]) begin
      ag = PAT_OFF;
      ar = PAT_ON;
    end else if (r.axis_ctrl[AX_ERR1]) begin
      ag = PAT_ON;
      ar = PAT_QUICK;
    end else if (r.axis_ctrl[AX_BOOTING]) begin
      // opposite phases of the same wave keep the alternation exact
      ag = PAT_SLOW_INV;
      ar = PAT_SLOW;
    end else if (r.axis_ctrl[AX_NO_CFG] || r.axis_ctrl[AX_NO_PROG] ||
                 r.axis_ctrl[AX_NO_FDBK] || r.axis_ctrl[AX_HALL_BAD]) begin
      ag = PAT_OFF;
      ar = PAT_SLOW;
    end else if (r.axis_ctrl[AX_COMMUT]) begin
      ag = PAT_QUICK;
    end else if (r.axis_ctrl[AX_POWERED]) begin
      ag = PAT_ON;
    end else begin
      ag = PAT_SLOW;
    end
  end

  // mains supply module pattern
  always_comb begin
    sst = dsle_sup_state_type'(r.sup_ctrl[SP_STATE_LSB +: 2]);
    sg = PAT_OFF;
    sr = PAT_OFF;
    case (sst)
      SUP_INIT: begin
        sg = PAT_SLOW;
        sr = PAT_QUICK;
      end
      SUP_ERROR: begin
        sg = PAT_SLOW;
        sr = PAT_ON;
      end
      SUP_BOOT: begin
        sg = PAT_SLOW;
        sr = PAT_SLOW;
      end
      SUP_RUN: begin
        sg = PAT_ON;
        sr = PAT_OFF;
      end
      default: begin
        sg = PAT_OFF;
        sr = PAT_OFF;
      end
    endcase
    // address indications only steer green; red keeps the state's pattern
    if (sst != SUP_ERROR && sst != SUP_BOOT) begin
      if (r.sup_ctrl[SP_ADDR_ACT]) begin
        sg = PAT_QUICK;
      end else if (r.sup_ctrl[SP_ADDR_DONE] && sst == SUP_INIT) begin
        sg = PAT_SLOW;
      end
    end
    if (r.sup_ctrl[SP_MOD_ERR]) begin
      sg = PAT_OFF;
      sr = PAT_ON;
    end
    if (!r.sup_ctrl[SP_CTRL24_OK]) begin
      sg = PAT_OFF;
      sr = PAT_OFF;
    end
  end

  assign setup = psel_i && !penable_i;
  assign access = psel_i && penable_i;
  assign mapped = is_mapped(paddr_i);
  assign wr = access && pwrite_i && mapped;

  always_comb begin
    next_r = r;
    ev = '0;
    // writes, byte lanes honoured
    if (wr && paddr_i == AXIS_CTRL_OFS) begin
      if (pstrb_i[0]) begin
        next_r.axis_ctrl[7:0] = pwdata_i[7:0];
      end
      if (pstrb_i[1]) begin
        next_r.axis_ctrl[AX_W-1:8] = pwdata_i[AX_W-1:8];
      end
    end
    if (wr && paddr_i == SUP_CTRL_OFS && pstrb_i[0]) begin
      next_r.sup_ctrl = pwdata_i[SP_W-1:0];
    end
    if (wr && paddr_i == IRQ_EN_OFS && pstrb_i[0]) begin
      next_r.irq_en = pwdata_i[IRQ_W-1:0];
    end
    // pattern registers and led levels
    next_r.ax_grn = ag;
    next_r.ax_red = ar;
    next_r.sp_grn = sg;
    next_r.sp_red = sr;
    next_r.lvl = {pat_level(sr, slow, quick), pat_level(sg, slow, quick),
                  pat_level(ar, slow, quick), pat_level(ag, slow, quick)};
    next_r.mod_err = r.sup_ctrl[SP_MOD_ERR] && r.sup_ctrl[SP_CTRL24_OK];
    next_r.hw_fault = r.axis_ctrl[AX_HW_FAULT];
    // events
    ev[IRQ_AXIS_CHG] = (ag != r.ax_grn) || (ar != r.ax_red);
    ev[IRQ_SUP_CHG] = (sg != r.sp_grn) || (sr != r.sp_red);
    ev[IRQ_MOD_ERR] = next_r.mod_err && !r.mod_err;
    ev[IRQ_HW_FAULT] = next_r.hw_fault && !r.hw_fault;
    // a new event beats a simultaneous clear
    next_r.irq_stat = r.irq_stat | ev;
    if (wr && paddr_i == IRQ_CLR_OFS && pstrb_i[0]) begin
      next_r.irq_stat = (r.irq_stat & ~pwdata_i[IRQ_W-1:0]) | ev;
    end
    // read data captured in the setup phase
    if (setup) begin
      next_r.rdata = 32'h0000_0000;
      case (paddr_i)
        AXIS_CTRL_OFS: next_r.rdata[AX_W-1:0] = r.axis_ctrl;
        SUP_CTRL_OFS: next_r.rdata[SP_W-1:0] = r.sup_ctrl;
        LED_STAT_OFS: begin
          next_r.rdata[ST_AX_GRN +: 3] = r.ax_grn;
          next_r.rdata[ST_AX_RED +: 3] = r.ax_red;
          next_r.rdata[ST_SP_GRN +: 3] = r.sp_grn;
          next_r.rdata[ST_SP_RED +: 3] = r.sp_red;
          next_r.rdata[ST_MOD_ERR] = r.mod_err;
          next_r.rdata[ST_LEVELS +: 4] = r.lvl;
        end
        IRQ_STAT_OFS: next_r.rdata[IRQ_W-1:0] = r.irq_stat;
        IRQ_EN_OFS: next_r.rdata[IRQ_W-1:0] = r.irq_en;
        default: next_r.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      r <= '0;
      r.axis_ctrl <= AXIS_CTRL_RST;
      r.sup_ctrl <= SUP_CTRL_RST;
      r.irq_stat <= IRQ_RST;
      r.irq_en <= IRQ_RST;
      r.ax_grn <= PAT_OFF;
      r.ax_red <= PAT_OFF;
      r.sp_grn <= PAT_OFF;
      r.sp_red <= PAT_OFF;
    end else begin
      r <= next_r;
    end
  end

  assign prdata_o = r.rdata;
  assign pready_o = 1'b1;
  assign pslverr_o = access && !mapped;
  assign axis_led_green_o = r.lvl[0];
  assign axis_led_red_o = r.lvl[1];
  assign sup_led_green_o = r.lvl[2];
  assign sup_led_red_o = r.lvl[3];
  assign sup_error_o = r.mod_err;
  assign irq_o = |(r.irq_stat & r.irq_en);

endmodule // dsle_led_top
`default_nettype wire

/* inc/dsle_pkg.sv */
// Purpose: constants and types for the drive status led encoder
// Assumes: 100 MHz ref_clk_i, apb register access, 32-bit data
// Notes: flash rates are free choices, see timing constants
package dsle_pkg;

  localparam logic [7:0] AXIS_CTRL_OFS = 8'h00;
  localparam logic [7:0] SUP_CTRL_OFS = 8'h04;
  localparam logic [7:0] LED_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h0C;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h10;
  localparam logic [7:0] IRQ_EN_OFS = 8'h14;

  // axis controller condition bits
  localparam int AX_W = 11;
  localparam int AX_SUPPLY_OK = 0;
  localparam int AX_BOOTING = 1;
  localparam int AX_NO_CFG = 2;
  localparam int AX_NO_PROG = 3;
  localparam int AX_NO_FDBK = 4;
  localparam int AX_HALL_BAD = 5;
  localparam int AX_POWERED = 6;
  localparam int AX_COMMUT = 7;
  localparam int AX_ERR1 = 8;
  localparam int AX_ERR2 = 9;
  localparam int AX_HW_FAULT = 10;
  localparam logic [AX_W-1:0] AXIS_CTRL_RST = 11'h000;

  // mains supply module condition bits
  localparam int SP_W = 6;
  localparam int SP_CTRL24_OK = 0;
  localparam int SP_MOD_ERR = 1;
  localparam int SP_ADDR_ACT = 2;
  localparam int SP_ADDR_DONE = 3;
  localparam int SP_STATE_LSB = 4;
  localparam logic [SP_W-1:0] SUP_CTRL_RST = 6'h00;

  // status word layout
  localparam int ST_AX_GRN = 0;
  localparam int ST_AX_RED = 3;
  localparam int ST_SP_GRN = 6;
  localparam int ST_SP_RED = 9;
  localparam int ST_MOD_ERR = 12;
  localparam int ST_LEVELS = 13;

  // interrupt bits
  localparam int IRQ_W = 4;
  localparam int IRQ_AXIS_CHG = 0;
  localparam int IRQ_SUP_CHG = 1;
  localparam int IRQ_MOD_ERR = 2;
  localparam int IRQ_HW_FAULT = 3;
  localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;

  // timing
  localparam int CLK_KHZ = 100000;
  localparam int SLOW_HALF_MS = 500;
  localparam int QUICK_HALF_MS = 125;
  localparam int QUICK_HALF_CYC_DEF = QUICK_HALF_MS * CLK_KHZ;
  localparam int QUICK_PER_SLOW = SLOW_HALF_MS / QUICK_HALF_MS;

  typedef enum logic [2:0] {
    PAT_OFF = 3'h0,
    PAT_ON = 3'h1,
    PAT_SLOW = 3'h2,
    PAT_QUICK = 3'h3,
    PAT_SLOW_INV = 3'h6
  } dsle_pat_type;

  typedef enum logic [1:0] {
    SUP_INIT = 2'h0,
    SUP_RUN = 2'h1,
    SUP_ERROR = 2'h3,
    SUP_BOOT = 2'h2
  } dsle_sup_state_type;

endpackage

/* hw/dsle_flash_gen.sv */
// Purpose: slow and quick square waves for led flashing
// Assumes: single clock, synchronous active high reset
// Notes: quick half period is a parameter so simulation can shorten it
`timescale 1ns/1ns
`default_nettype none
module dsle_flash_gen #(
  parameter int QUICK_HALF_CYC = dsle_pkg::QUICK_HALF_CYC_DEF,
  parameter int QUICK_PER_SLOW = dsle_pkg::QUICK_PER_SLOW
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  output logic slow_o,
  output logic quick_o
);
  import dsle_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;
    logic [7:0] sub;
    logic slow;
    logic quick;
  } dsle_flash_type;

  dsle_flash_type r;
  dsle_flash_type next_r;

  always_comb begin
    next_r = r;
    if (r.cnt == 32'(QUICK_HALF_CYC - 1)) begin
      // one enable pulse per quick half period
      next_r.cnt = 32'h0000_0000;
      next_r.quick = ~r.quick;
      if (r.sub == 8'(QUICK_PER_SLOW - 1)) begin
        next_r.sub = 8'h00;
        next_r.slow = ~r.slow;
      end else begin
        next_r.sub = r.sub + 8'h01;
      end
    end else begin
      next_r.cnt = r.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign slow_o = r.slow;
  assign quick_o = r.quick;

endmodule // dsle_flash_gen
`default_nettype wire

/* bench/dsle_led_chk.sv */
// Purpose: port checker for the led encoder
// Assumes: control writes use every byte lane
// Notes: shadows the control words from apb writes
`timescale 1ns/1ns
`default_nettype none
module dsle_led_chk (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic axis_led_green_o,
  input wire logic axis_led_red_o,
  input wire logic sup_led_green_o,
  input wire logic sup_led_red_o,
  input wire logic sup_error_o
);
  import dsle_pkg::*;
  logic [10:0] ax;
  logic [5:0] sp;
  logic wr, ag, ar, sg, sr;
  assign wr = psel_i && penable_i && pwrite_i;
  assign ag = axis_led_green_o;
  assign ar = axis_led_red_o;
  assign sg = sup_led_green_o;
  assign sr = sup_led_red_o;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ax <= '0;
      sp <= '0;
    end else if (wr && paddr_i == AXIS_CTRL_OFS) begin
      ax <= pwdata_i[10:0];
    end else if (wr && paddr_i == SUP_CTRL_OFS) begin
      sp <= pwdata_i[5:0];
    end
  end
  // leds lag a write by one edge, so only settled words are judged
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  ax_dark_a: assert property ($stable(ax) && !ax[0] |-> !ag && !ar)
    else $error("axis leds lit");
  ax_fault_a: assert property ($stable(ax) && ax[0] && ax[10]
    |-> ag && ar) else $error("fault not shown");
  ax_err2_a: assert property ($stable(ax) && ax[10:9] == 2'h1 && ax[0]
    |-> ar && !ag) else $error("error two wrong");
  ax_err1_a: assert property ($stable(ax) && ax[10:8] == 3'h1 && ax[0]
    |-> ag) else $error("error one wrong");
  ax_boot_a: assert property ($stable(ax) && ax[10:8] == 3'h0
    && ax[1:0] == 2'h3 |-> ag != ar) else $error("boot not alternating");
  ax_pwr_a: assert property ($stable(ax) && ax == 11'h041 |-> ag && !ar)
    else $error("powered wrong");
  sp_dark_a: assert property ($stable(sp) && !sp[0] |-> !sg && !sr
    && !sup_error_o) else $error("supply leds lit");
  sp_err_a: assert property ($stable(sp) && sp[1:0] == 2'h3
    |-> sr && !sg && sup_error_o) else $error("module error wrong");
  sp_boot_a: assert property ($stable(sp) && sp[5:4] == 2'h2
    && sp[1:0] == 2'h1 |-> sg == sr) else $error("bootloader wrong");
  cover property (ax[1:0] == 2'h3);
  cover property (sp[1:0] == 2'h3);
  cover property (sp[5:4] == 2'h2 && sp[0]);
endmodule // dsle_led_chk
bind dsle_led_top dsle_led_chk i_chk (.ref_clk_i, .sys_rst_i, .paddr_i,
  .psel_i, .penable_i, .pwrite_i, .pwdata_i, .axis_led_green_o,
  .axis_led_red_o, .sup_led_green_o, .sup_led_red_o, .sup_error_o);
`default_nettype wire

/* bench/dsle_led_panel.sv */
// Purpose: front panel led as seen by the operator
// Assumes: led lit while its input is high
// Notes: reports how many cycles the last level lasted
`timescale 1ns/1ns
`default_nettype none
module dsle_led_panel (
  input wire logic ref_clk_i,
  input wire logic led_i,
  output var int half_o
);
  logic prev = 1'b0;
  int run = 0;
  always @(posedge ref_clk_i) begin
    prev <= led_i;
    run <= (led_i != prev) ? 0 : run + 1;
    if (led_i != prev) half_o <= run + 1;
  end
endmodule // dsle_led_panel
`default_nettype wire

/* bench/testbench.sv */
// Purpose: self-checking bench for the led encoder
// Assumes: quick half period shortened to QH cycles
// Notes: patterns read over apb, rates measured by the panel
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import dsle_pkg::*;
  localparam int QH = 4;
  localparam logic [10:0] AXV [11] = '{11'h000, 11'h003, 11'h005,
    11'h011, 11'h021, 11'h001, 11'h0C1, 11'h141, 11'h201, 11'h401, 11'h7FF};
  localparam logic [5:0] SPV [9] = '{6'h00, 6'h03, 6'h05, 6'h09, 6'h11,
    6'h31, 6'h21, 6'h15, 6'h3F};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, ag, ar, sg, sr, serr, irq, err;
  int half;
  int n_errors = 0;
  int n_tests = 0;
  dsle_led_top #(.QUICK_HALF_CYC(QH)) i_dut (.ref_clk_i(clk),
    .sys_rst_i(rst), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .pwdata_i(pwdata), .pstrb_i(4'hF),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .axis_led_green_o(ag), .axis_led_red_o(ar), .sup_led_green_o(sg),
    .sup_led_red_o(sr), .sup_error_o(serr), .irq_o(irq));
  dsle_led_panel i_pan (.ref_clk_i(clk), .led_i(ag), .half_o(half));
  initial forever #5 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] e, s);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // {module error, sup red, sup green, axis red, axis green}
  function automatic logic [12:0] expect_stat(logic [10:0] a, logic [5:0] s);
    logic [11:0] p;
    p = 12'h000;
    if (!a[0]) p[5:0] = 6'h00;
    else if (a[10]) p[5:0] = 6'h09;
    else if (a[9]) p[5:0] = 6'h08;
    else if (a[8]) p[5:0] = 6'h19;
    else if (a[1]) p[5:0] = 6'h16;
    else if (|a[5:2]) p[5:0] = 6'h10;
    else if (a[7]) p[5:0] = 6'h03;
    else p[5:0] = a[6] ? 6'h01 : 6'h02;
    if (!s[0]) p[11:6] = 6'h00;
    else if (s[1]) p[11:6] = 6'h08;
    else begin
      p[11:6] = s[5:4] == 2'h0 ? 6'h1A : s[5:4] == 2'h1 ? 6'h01 :
        s[5:4] == 2'h3 ? 6'h0A : 6'h12;
      if (s[2] && !s[5]) p[8:6] = 3'h3;
    end
    return {s[1] & s[0], p};
  endfunction
  task automatic try(input logic [10:0] a, input logic [5:0] s);
    logic [12:0] e;
    e = expect_stat(a, s);
    apb(1'b1, AXIS_CTRL_OFS, 32'(a), q);
    apb(1'b1, SUP_CTRL_OFS, 32'(s), q);
    apb(1'b0, LED_STAT_OFS, 32'h0, q);
    chk("axis", 32'(e[5:0]), 32'(q[5:0]));
    chk("sup", 32'(e[11:6]), 32'(q[11:6]));
    chk("sup_error", 32'(e[12]), 32'(serr));
    chk("stat_error", 32'(e[12]), 32'(q[12]));
    chk("slverr", 32'h0, 32'(err));
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    complete_run();
  end
  initial begin
    void'($urandom(32'hF9A2));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("leds", 32'h0, {28'h0, ag, ar, sg, sr});
    $display("test reset done");
    foreach (AXV[i]) begin
      foreach (SPV[j]) try(AXV[i], SPV[j]);
    end
    for (int i = 0; i < 60; i++) try(11'($urandom) >> (i % 5), 6'($urandom));
    $display("test patterns done");
    try(11'h0C1, 6'h00);
    repeat (60) @(posedge clk);
    chk("quick", QH, half);
    try(11'h001, 6'h00);
    repeat (120) @(posedge clk);
    chk("slow", QH * QUICK_PER_SLOW, half);
    $display("test rates done");
    apb(1'b1, IRQ_CLR_OFS, 32'hF, q);
    apb(1'b1, IRQ_EN_OFS, 32'h1, q);
    apb(1'b1, AXIS_CTRL_OFS, 32'h41, q);
    repeat (3) @(negedge clk);
    chk("irq set", 32'h1, 32'(irq));
    apb(1'b0, IRQ_STAT_OFS, 32'h0, q);
    chk("irq stat", 32'h1, q & 32'h1);
    apb(1'b1, IRQ_EN_OFS, 32'h0, q);
    repeat (3) @(negedge clk);
    chk("irq mask", 32'h0, 32'(irq));
    apb(1'b1, IRQ_CLR_OFS, 32'h1, q);
    apb(1'b1, IRQ_EN_OFS, 32'h1, q);
    repeat (3) @(negedge clk);
    chk("irq clear", 32'h0, 32'(irq));
    apb(1'b0, 8'h40, 32'h0, q);
    chk("unmapped", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, q);
    $display("test bus done");
    complete_run();
  end
endmodule // testbench
`default_nettype wire
